// file: hw/dmx_core.sv
// Behaviour
// RQ1 - File copy reads register f, writes it to accumulator (d=0) or back (d=1).
// RQ2 - File copy sets the zero flag from the moved value, either destination.
// RQ3 - Indirect load fills accumulator from pointer target and sets the zero flag.
// RQ4 - Update code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec; pointer keeps it.
// RQ5 - Offset form addresses pointer plus signed -32..31 literal; pointer unchanged.
// RQ6 - Pointers are 16 bits and wrap modulo 65536 on increment or decrement.
// RQ7 - Window files have no storage; they access memory at the pointer's address.
// RQ8 - Page literal loads 5-bit value into page select; flags unchanged.
// RQ9 - Code page literal loads 7-bit value into the code page latch; flags unchanged.
// RQ10 - Literal load puts 8-bit literal in accumulator; flags unchanged.
// RQ11 - Accumulator store writes accumulator to file register f; flags unchanged.
// RQ12 - Copy, literal load and store each take one word and one cycle.
`default_nettype none
module dmx_core (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic [7:0] o_accumulator,
	output logic o_zero_flag,
	output logic [6:0] o_code_page_latch
);
	// ==========================================================
	// State.
	logic wait_q;
	logic wait_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [7:0] acc_q;
	logic [7:0] acc_d;
	logic zero_q;
	logic zero_d;
	logic [4:0] page_q;
	logic [4:0] page_d;
	logic [6:0] code_page_q;
	logic [6:0] code_page_d;
	logic [15:0] ptr0_q;
	logic [15:0] ptr0_d;
	logic [15:0] ptr1_q;
	logic [15:0] ptr1_d;
	logic [11:0] maddr_q;
	logic [11:0] maddr_d;

	// ==========================================================
	// Decode and datapath wires.
	dmx_mem_if mem ();
	dmx_pkg::dmx_op_t op;
	logic [13:0] word;
	logic exec;
	logic sel_ptr1;
	logic [15:0] sel_ptr;
	logic [15:0] ind_address;
	logic [15:0] ind_pointer_next;
	logic [11:0] file_address;

	// Window files resolve to the pointer target, all others to page:file.
	function automatic logic [11:0] file_target(input logic [6:0] f, input logic [4:0] page,
			input logic [15:0] p0, input logic [15:0] p1);
		logic [11:0] a;
		a = {page, f};
		if (f == dmx_pkg::WINDOW0_FILE) begin
			a = p0[11:0]; // RQ7
		end else if (f == dmx_pkg::WINDOW1_FILE) begin
			a = p1[11:0]; // RQ7
		end
		return a;
	endfunction

	assign word = i_avs_writedata[13:0];
	assign op = dmx_pkg::dmx_decode(word);
	// An instruction executes at the edge that completes its bus write.
	assign exec = i_avs_write && !wait_q && (i_avs_address == dmx_pkg::OFS_INSTR); // RQ12
	assign sel_ptr1 = (op == dmx_pkg::DMX_OP_INDIRECT_OFS) ? word[6] : word[2];
	assign sel_ptr = sel_ptr1 ? ptr1_q : ptr0_q;
	assign file_address = file_target(word[6:0], page_q, ptr0_q, ptr1_q);

	dmx_ptr_step u_ptr_step (
		.i_pointer(sel_ptr),
		.i_offset_form(op == dmx_pkg::DMX_OP_INDIRECT_OFS),
		.i_update_code(word[1:0]),
		.i_offset(word[5:0]),
		.o_address(ind_address),
		.o_pointer_next(ind_pointer_next)
	);

	dmx_data_mem u_data_mem (
		.i_clock(i_clock),
		.mem(mem)
	);

	// ==========================================================
	// Bus qualifiers and instruction strobes shared by the register groups.
	logic wr_take;
	logic rd_first;
	logic move_copy;
	logic move_ind;
	logic move_store;
	logic move_lit;
	logic move_page;
	logic move_code_page;
	logic [7:0] loaded;
	logic loaded_zero;

	// A register hit needs the accepting edge and the matching offset.
	function automatic logic reg_hit(input logic take, input logic [7:0] a,
			input logic [7:0] ofs);
		return take && (a == ofs);
	endfunction

	// The zero test is shared by every move that updates the flag.
	function automatic logic is_zero(input logic [7:0] v);
		return v == 8'h00;
	endfunction

	assign wr_take = i_avs_write && !wait_q;
	assign rd_first = i_avs_read && wait_q;
	assign move_copy = exec && (op == dmx_pkg::DMX_OP_FILE_COPY);
	assign move_ind = exec && ((op == dmx_pkg::DMX_OP_INDIRECT_LOAD) ||
		(op == dmx_pkg::DMX_OP_INDIRECT_OFS));
	assign move_store = exec && (op == dmx_pkg::DMX_OP_ACC_STORE);
	assign move_lit = exec && (op == dmx_pkg::DMX_OP_LITERAL_LOAD);
	assign move_page = exec && (op == dmx_pkg::DMX_OP_PAGE_LITERAL);
	assign move_code_page = exec && (op == dmx_pkg::DMX_OP_CODE_PAGE_LITERAL);
	assign loaded = mem.rdata;
	assign loaded_zero = is_zero(mem.rdata);

	// ==========================================================
	// Data memory port. Address and enable never depend on the read data,
	// so the combinational read cannot close a loop through this logic.
	always_comb begin
		mem.addr = maddr_q;
		mem.we = reg_hit(wr_take, i_avs_address, dmx_pkg::OFS_MEM_DATA);
		if (move_copy) begin
			mem.addr = file_address; // RQ1
			mem.we = word[7]; // RQ1
		end else if (move_ind) begin
			// Only the low address bits reach this memory depth.
			mem.addr = ind_address[11:0]; // RQ3
		end else if (move_store) begin
			mem.addr = file_address; // RQ11
			mem.we = 1'b1; // RQ11
		end
	end

	always_comb begin
		mem.wdata = i_avs_writedata[7:0];
		if (move_copy) begin
			mem.wdata = mem.rdata; // RQ1
		end else if (move_store) begin
			mem.wdata = acc_q; // RQ11
		end
	end

	// ==========================================================
	// Bus handshake. Waitrequest drops for exactly one cycle per request,
	// which keeps every move inside a single accepting edge.
	always_comb begin
		wait_d = 1'b1;
		rdata_d = rdata_q;
		if ((i_avs_read || i_avs_write) && wait_q) begin
			wait_d = 1'b0; // RQ12
		end
		if (rd_first) begin
			unique case (i_avs_address)
				dmx_pkg::OFS_ACC: rdata_d = {24'h000000, acc_q};
				dmx_pkg::OFS_STATUS: rdata_d = {31'h0, zero_q};
				dmx_pkg::OFS_PAGE: rdata_d = {27'h0, page_q};
				dmx_pkg::OFS_CODE_PAGE: rdata_d = {25'h0, code_page_q};
				dmx_pkg::OFS_PTR0: rdata_d = {16'h0000, ptr0_q};
				dmx_pkg::OFS_PTR1: rdata_d = {16'h0000, ptr1_q};
				dmx_pkg::OFS_MEM_ADDR: rdata_d = {20'h00000, maddr_q};
				dmx_pkg::OFS_MEM_DATA: rdata_d = {24'h000000, mem.rdata};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h00000000;
		end else begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// ==========================================================
	// Accumulator. A copy back to the file leaves it alone.
	always_comb begin
		acc_d = acc_q;
		if (reg_hit(wr_take, i_avs_address, dmx_pkg::OFS_ACC)) begin
			acc_d = i_avs_writedata[7:0];
		end
		if (move_copy && !word[7]) begin
			acc_d = loaded; // RQ1
		end
		if (move_ind) begin
			acc_d = loaded; // RQ3
		end
		if (move_lit) begin
			acc_d = word[7:0]; // RQ10
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			acc_q <= dmx_pkg::ACC_RESET;
		end else begin
			acc_q <= acc_d;
		end
	end

	// ==========================================================
	// Zero flag. Literal loads and stores never touch it; only moves
	// that read the data memory test the value they carry.
	always_comb begin
		zero_d = zero_q;
		if (reg_hit(wr_take, i_avs_address, dmx_pkg::OFS_STATUS)) begin
			zero_d = i_avs_writedata[dmx_pkg::STATUS_ZERO_BIT];
		end
		if (move_copy) begin
			zero_d = loaded_zero; // RQ2
		end
		if (move_ind) begin
			zero_d = loaded_zero; // RQ3
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			zero_q <= dmx_pkg::STATUS_ZERO_RESET;
		end else begin
			zero_q <= zero_d;
		end
	end

	// ==========================================================
	// Data page select.
	always_comb begin
		page_d = page_q;
		if (reg_hit(wr_take, i_avs_address, dmx_pkg::OFS_PAGE)) begin
			page_d = i_avs_writedata[4:0];
		end
		if (move_page) begin
			page_d = word[4:0]; // RQ8
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			page_q <= dmx_pkg::PAGE_RESET;
		end else begin
			page_q <= page_d;
		end
	end

	// ==========================================================
	// Code page latch.
	always_comb begin
		code_page_d = code_page_q;
		if (reg_hit(wr_take, i_avs_address, dmx_pkg::OFS_CODE_PAGE)) begin
			code_page_d = i_avs_writedata[6:0];
		end
		if (move_code_page) begin
			code_page_d = word[6:0]; // RQ9
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			code_page_q <= dmx_pkg::CODE_PAGE_RESET;
		end else begin
			code_page_q <= code_page_d;
		end
	end

	// ==========================================================
	// Pointer 0. The step logic wraps, so no bound check is needed here.
	always_comb begin
		ptr0_d = ptr0_q;
		if (reg_hit(wr_take, i_avs_address, dmx_pkg::OFS_PTR0)) begin
			ptr0_d = i_avs_writedata[15:0];
		end
		if (move_ind && !sel_ptr1) begin
			ptr0_d = ind_pointer_next; // RQ4
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			ptr0_q <= dmx_pkg::PTR_RESET;
		end else begin
			ptr0_q <= ptr0_d;
		end
	end

	// ==========================================================
	// Pointer 1.
	always_comb begin
		ptr1_d = ptr1_q;
		if (reg_hit(wr_take, i_avs_address, dmx_pkg::OFS_PTR1)) begin
			ptr1_d = i_avs_writedata[15:0];
		end
		if (move_ind && sel_ptr1) begin
			ptr1_d = ind_pointer_next; // RQ4
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			ptr1_q <= dmx_pkg::PTR_RESET;
		end else begin
			ptr1_q <= ptr1_d;
		end
	end

	// ==========================================================
	// Data memory address register for the bus window.
	always_comb begin
		maddr_d = maddr_q;
		if (reg_hit(wr_take, i_avs_address, dmx_pkg::OFS_MEM_ADDR)) begin
			maddr_d = i_avs_writedata[11:0];
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			maddr_q <= dmx_pkg::MEM_ADDR_RESET;
		end else begin
			maddr_q <= maddr_d;
		end
	end

	// ==========================================================
	// Outputs.
	assign o_avs_readdata = rdata_q;
	assign o_avs_waitrequest = wait_q;
	assign o_accumulator = acc_q;
	assign o_zero_flag = zero_q;
	assign o_code_page_latch = code_page_q;
endmodule
`default_nettype wire

// file: hw/dmx_pkg.sv
`default_nettype none
package dmx_pkg;
	// ==========================================================
	// Register map, byte addresses on the Avalon-MM slave.
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_ACC = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_PAGE = 8'h0C;
	localparam logic [7:0] OFS_CODE_PAGE = 8'h10;
	localparam logic [7:0] OFS_PTR0 = 8'h14;
	localparam logic [7:0] OFS_PTR1 = 8'h18;
	localparam logic [7:0] OFS_MEM_ADDR = 8'h1C;
	localparam logic [7:0] OFS_MEM_DATA = 8'h20;

	// ==========================================================
	// Field positions and reset values.
	localparam int unsigned STATUS_ZERO_BIT = 0;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic STATUS_ZERO_RESET = 1'b0;
	localparam logic [4:0] PAGE_RESET = 5'h00;
	localparam logic [6:0] CODE_PAGE_RESET = 7'h00;
	localparam logic [15:0] PTR_RESET = 16'h0000;
	localparam logic [11:0] MEM_ADDR_RESET = 12'h000;

	// ==========================================================
	// Data memory geometry and indirect windows.
	localparam int unsigned MEM_AW = 12;
	localparam int unsigned MEM_DEPTH = 4096;
	localparam logic [6:0] WINDOW0_FILE = 7'h00;
	localparam logic [6:0] WINDOW1_FILE = 7'h01;

	// ==========================================================
	// Instruction encodings, 14-bit words.
	localparam logic [5:0] ENC_LITERAL_LOAD = 6'h30;
	localparam logic [6:0] ENC_CODE_PAGE = 7'h63;
	localparam logic [8:0] ENC_PAGE = 9'h001;
	localparam logic [6:0] ENC_ACC_STORE = 7'h01;
	localparam logic [5:0] ENC_FILE_COPY = 6'h08;
	localparam logic [10:0] ENC_INDIRECT = 11'h002;
	localparam logic [6:0] ENC_INDIRECT_OFS = 7'h7E;

	typedef enum {
		DMX_OP_NONE,
		DMX_OP_FILE_COPY,
		DMX_OP_INDIRECT_LOAD,
		DMX_OP_INDIRECT_OFS,
		DMX_OP_PAGE_LITERAL,
		DMX_OP_CODE_PAGE_LITERAL,
		DMX_OP_LITERAL_LOAD,
		DMX_OP_ACC_STORE
	} dmx_op_t;

	function automatic dmx_op_t dmx_decode(input logic [13:0] w);
		dmx_op_t op;
		op = DMX_OP_NONE;
		if (w[13:8] == ENC_LITERAL_LOAD) begin
			op = DMX_OP_LITERAL_LOAD;
		end else if (w[13:7] == ENC_CODE_PAGE) begin
			op = DMX_OP_CODE_PAGE_LITERAL;
		end else if (w[13:5] == ENC_PAGE) begin
			op = DMX_OP_PAGE_LITERAL;
		end else if (w[13:7] == ENC_ACC_STORE) begin
			op = DMX_OP_ACC_STORE;
		end else if (w[13:8] == ENC_FILE_COPY) begin
			op = DMX_OP_FILE_COPY;
		end else if (w[13:3] == ENC_INDIRECT) begin
			op = DMX_OP_INDIRECT_LOAD;
		end else if (w[13:7] == ENC_INDIRECT_OFS) begin
			op = DMX_OP_INDIRECT_OFS;
		end
		return op;
	endfunction
endpackage
`default_nettype wire

// file: hw/dmx_mem_if.sv
`default_nettype none
interface dmx_mem_if;
	logic [11:0] addr;
	logic [7:0] wdata;
	logic we;
	logic [7:0] rdata;
	modport core (output addr, output wdata, output we, input rdata);
	modport store (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// file: hw/dmx_data_mem.sv
`default_nettype none
module dmx_data_mem (
	input wire logic i_clock,
	dmx_mem_if.store mem
);
	// ==========================================================
	// Byte-wide data memory, combinational read, clocked write.
	// The read is combinational so a whole move fits in one cycle.
	logic [7:0] cells [0:dmx_pkg::MEM_DEPTH-1];

	always_ff @(posedge i_clock) begin
		if (mem.we) begin
			cells[mem.addr] <= mem.wdata;
		end
	end

	assign mem.rdata = cells[mem.addr];
endmodule
`default_nettype wire

// file: hw/dmx_ptr_step.sv
`default_nettype none
module dmx_ptr_step (
	input wire logic [15:0] i_pointer,
	input wire logic i_offset_form,
	input wire logic [1:0] i_update_code,
	input wire logic [5:0] i_offset,
	output logic [15:0] o_address,
	output logic [15:0] o_pointer_next
);
	// ==========================================================
	// Effective address and pointer update for indirect access.
	logic [15:0] adjusted;

	always_comb begin
		adjusted = i_pointer + (i_update_code[0] ? 16'hFFFF : 16'h0001); // RQ6
		if (i_offset_form) begin
			o_address = i_pointer + {{10{i_offset[5]}}, i_offset}; // RQ5
			o_pointer_next = i_pointer; // RQ5
		end else begin
			o_address = i_update_code[1] ? i_pointer : adjusted; // RQ4
			o_pointer_next = adjusted; // RQ4
		end
	end
endmodule
`default_nettype wire

// file: test/dmx_core_asserts.sv
`default_nettype none
// ==========
// Port checks.
module dmx_core_asserts (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic [7:0] o_accumulator,
	input wire logic o_zero_flag,
	input wire logic [6:0] o_code_page_latch
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic [13:0] w = i_avs_writedata[13:0];
	wire logic [7:0] k8 = i_avs_writedata[7:0];
	wire logic [6:0] k7 = i_avs_writedata[6:0];
	wire logic z_ok = o_zero_flag == (o_accumulator == 8'h00);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);
	sequence s_go;
		i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h00;
	endsequence
	sequence s_keep;
		$stable(o_zero_flag) && $stable(o_accumulator);
	endsequence
	a_wait_one: assert property (o_avs_waitrequest && (i_avs_read || i_avs_write)
		|=> !o_avs_waitrequest) else $error("slow answer");
	a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("long answer");
	a_lit_acc: assert property (s_go ##0 w[13:8] == dmx_pkg::ENC_LITERAL_LOAD
		|=> o_accumulator == $past(k8) && $stable(o_zero_flag)) else $error("literal");
	a_code_page: assert property (s_go ##0 w[13:7] == dmx_pkg::ENC_CODE_PAGE
		|=> o_code_page_latch == $past(k7) ##0 s_keep) else $error("code page");
	a_page_keep: assert property (s_go ##0 w[13:5] == dmx_pkg::ENC_PAGE |=> s_keep)
		else $error("page");
	a_store_keep: assert property (s_go ##0 w[13:7] == dmx_pkg::ENC_ACC_STORE
		|=> s_keep) else $error("store");
	a_copy_zero: assert property (s_go ##0 w[13:7] == {dmx_pkg::ENC_FILE_COPY, 1'b0}
		|=> z_ok) else $error("copy zero");
	a_copy_back: assert property (s_go ##0 w[13:7] == {dmx_pkg::ENC_FILE_COPY, 1'b1}
		|=> $stable(o_accumulator)) else $error("copy back");
	a_ind_zero: assert property (s_go ##0 (w[13:3] == dmx_pkg::ENC_INDIRECT ||
		w[13:7] == dmx_pkg::ENC_INDIRECT_OFS) |=> z_ok) else $error("indirect zero");
endmodule
bind dmx_core dmx_core_asserts chk_u (.i_clock, .i_reset, .i_avs_address, .i_avs_read,
	.i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
	.o_accumulator, .o_zero_flag, .o_code_page_latch);
`default_nettype wire

// file: test/dmx_core_tb_top.sv
`default_nettype none
module dmx_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// Bench.
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	wire logic [31:0] rdo;
	wire logic wt;
	wire logic z;
	wire logic [7:0] acc;
	wire logic [6:0] cpl;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	dmx_core dut_u (.i_clock(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdo),
		.o_avs_waitrequest(wt), .o_accumulator(acc), .o_zero_flag(z),
		.o_code_page_latch(cpl));
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, e); end end
	initial begin
		forever #10 clk = ~clk;
	end
	// The ceiling is far above the few hundred cycles the tests need.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("compared %0d, mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		while (wt !== 1'b0) @(posedge clk);
		rdat = rdo;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	// Ports are looked at one half cycle after the executing edge.
	task automatic ex(input logic [13:0] i);
		xfer(8'h00, {18'h0, i}, 1'b1);
		@(negedge clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		xfer(a, 32'h0, 1'b0);
		`CHK(rdat, e)
	endtask
	task automatic mw(input logic [11:0] a, input logic [7:0] d);
		xfer(8'h1C, {20'h0, a}, 1'b1);
		xfer(8'h20, {24'h0, d}, 1'b1);
	endtask
	task automatic mr(input logic [11:0] a, input logic [7:0] e);
		xfer(8'h1C, {20'h0, a}, 1'b1);
		rchk(8'h20, {24'h0, e});
	endtask
	task automatic t_reset();
		logic [7:0] ofs [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};
		xfer(8'h40, 32'hFF, 1'b1);
		foreach (ofs[j]) rchk(ofs[j], 32'h0);
		$display("reset test done");
	endtask
	task automatic t_lit();
		logic [7:0] lv [3] = '{8'hFF, 8'h00, 8'h5A};
		xfer(8'h08, 32'h1, 1'b1);
		foreach (lv[j]) begin
			ex({6'h30, lv[j]});
			`CHK(acc, lv[j])
			`CHK(z, 1'b1)
		end
		ex(14'h3FFF);
		`CHK(acc, 8'h5A)
		$display("literal test done");
	endtask
	task automatic t_page();
		ex(14'h003F);
		rchk(8'h0C, 32'h1F);
		ex(14'h31FF);
		`CHK(cpl, 7'h7F)
		`CHK(z, 1'b1)
		rchk(8'h08, 32'h1);
		ex(14'h0022);
		$display("page test done");
	endtask
	task automatic t_copy();
		ex(14'h00C5);
		mr(12'h145, 8'h5A);
		`CHK(z, 1'b1)
		ex(14'h3000);
		ex(14'h0845);
		`CHK(acc, 8'h5A)
		`CHK(z, 1'b0)
		mw(12'h17F, 8'h00);
		ex(14'h08FF);
		`CHK(z, 1'b1)
		`CHK(acc, 8'h5A)
		mr(12'h17F, 8'h00);
		$display("copy test done");
	endtask
	task automatic t_win();
		xfer(8'h14, 32'h145, 1'b1);
		ex(14'h3000);
		ex(14'h0800);
		`CHK(acc, 8'h5A)
		xfer(8'h18, 32'h200, 1'b1);
		ex(14'h0081);
		mr(12'h200, 8'h5A);
		$display("window test done");
	endtask
	task automatic t_ind();
		logic [15:0] p;
		mw(12'h000, 8'h11);
		mw(12'hFFF, 8'h22);
		for (int i = 0; i < 4; i++) begin
			p = i[0] ? 16'h0000 : 16'hFFFF;
			xfer(8'h14 + 8'(4 * i[1]), {16'h0, p}, 1'b1);
			xfer(8'h08, 32'h1, 1'b1);
			ex(14'h0010 + 14'(4 * i[1] + i[1:0]));
			`CHK(acc, (i == 0 || i == 3) ? 8'h11 : 8'h22)
			`CHK(z, 1'b0)
			rchk(8'h14 + 8'(4 * i[1]), {16'h0, ~p});
		end
		$display("indirect test done");
	endtask
	task automatic t_ofs();
		xfer(8'h18, 32'h10, 1'b1);
		mw(12'hFF0, 8'h00);
		mw(12'h02F, 8'h77);
		ex(14'h3F60);
		`CHK(acc, 8'h00)
		`CHK(z, 1'b1)
		ex(14'h3F5F);
		`CHK(acc, 8'h77)
		`CHK(z, 1'b0)
		rchk(8'h18, 32'h10);
		$display("offset test done");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_lit();
		t_page();
		t_copy();
		t_win();
		t_ind();
		t_ofs();
		finish_test();
	end
endmodule
`default_nettype wire
